// *** spr_map.vh ***
`ifndef SPR_MAP_VH
`define SPR_MAP_VH

// frame layout
`define SPR_HDR_BITS 5'd16
`define SPR_FRAME_LAST 5'd23
`define SPR_ADDR_W 15

// register offsets
`define SPR_A_CFG_A 15'h0000
`define SPR_A_DEV_CFG 15'h0002
`define SPR_A_MAKER_LO 15'h000c
`define SPR_A_MAKER_HI 15'h000d
`define SPR_A_USR_CFG 15'h0010
`define SPR_A_CLK0 15'h0029
`define SPR_A_CLK1 15'h002a
`define SPR_A_CLK2 15'h002b
`define SPR_A_SYSREF 15'h002c
`define SPR_A_FS_LO 15'h0030
`define SPR_A_FS_HI 15'h0031
`define SPR_A_LP1 15'h0037
`define SPR_A_TMSTP 15'h003b
`define SPR_A_REFO 15'h003c
`define SPR_A_DIV_VP 15'h003d
`define SPR_A_DIV_N 15'h003e
`define SPR_A_OSC_CTL 15'h003f
`define SPR_A_SER_EMPH 15'h0048
`define SPR_A_TRIG 15'h0057
`define SPR_A_PIN_OVR 15'h0058
`define SPR_A_OSC_TRIM 15'h0059
`define SPR_A_CAL_RST 15'h005c
`define SPR_A_OSC_CAL 15'h005d
`define SPR_A_OSC_STATE 15'h005e
`define SPR_A_CAL_ON 15'h0061
`define SPR_A_CAL_S0 15'h0062
`define SPR_A_CAL_S1 15'h0065
`define SPR_A_CAL_MEAN 15'h0068
`define SPR_A_CAL_STATE 15'h006a
`define SPR_A_CAL_PIN 15'h006b
`define SPR_A_CAL_TRIG 15'h006c
`define SPR_A_CAL_LOWP 15'h006e
`define SPR_A_GAIN_DAC 15'h007a
`define SPR_A_BANDGAP 15'h007c
`define SPR_A_TERM_A 15'h007e
`define SPR_A_TERM_B 15'h007f
`define SPR_A_TERM_C 15'h0080
`define SPR_A_TERM_D 15'h0081
`define SPR_A_SRC_DLY 15'h009a
`define SPR_A_SEL_DLY 15'h009b
`define SPR_A_DITHER 15'h009d
`define SPR_A_LSB_OUT 15'h0160
`define SPR_A_SERDES_EN 15'h0200
`define SPR_A_LINK_MODE 15'h0201

// reset values (undefined ones read zero)
`define SPR_R_CFG_A 8'h30
`define SPR_R_CLK0 8'h80
`define SPR_R_CLK2 8'h10
`define SPR_R_FS_HI 8'ha0
`define SPR_R_LP1 8'h4b
`define SPR_R_ONE 8'h01
`define SPR_R_DIV_N 8'h20
`define SPR_R_OSC_CTL 8'h4f
`define SPR_R_OSC_CAL 8'h40
`define SPR_R_CAL_MEAN 8'h61
`define SPR_R_CAL_LOWP 8'h88
`define SPR_R_ZERO 8'h00

// field positions
`define SPR_CFG_A_DIR_UP 5
`define SPR_USR_ADDR_HOLD 0

// storage indices of special registers
`define SPR_I_CFG_A 6'd0
`define SPR_I_USR_CFG 6'd4
`define SPR_NREG 44

`endif

// *** spr_port.v ***
// How it works
// - select low frames access; high ignores traffic
// - input bits captured on serial clock rise
// - no timeout; state held while clock stopped
// - frame is flag, address, one data byte
// - every field shifts most significant bit first
// - wide registers little-endian, low byte first
// - output undriven in writes and read header
// - first bit one reads, zero writes
// - next fifteen bits give register address
// - write stores final eight bits
// - read ignores data in, drives register out
// - select held low streams further data bytes
// - streaming steps address up, or down
// - address hold bit stops address stepping
// - direction bit in register zero, resets 0x30
`timescale 1ns/1ps
`default_nettype none
`include "spr_map.vh"

module spr_port #(
	parameter [15:0] MAKER_CODE = 16'h5a3c // arbitrary value
) (
	// clock and reset
	input wire clock,
	input wire reset_n,
	// serial pins
	input wire serial_select_n,
	input wire serial_clock,
	input wire serial_data_in,
	output reg serial_data_out,
	output reg serial_data_out_oe,
	// read-only status from the converter
	input wire [7:0] sysref_capture_window,
	input wire [7:0] osc_cal_state,
	input wire [7:0] calibration_state
);

	reg sel_s1_q, sel_s2_q;
	reg clk_s1_q, clk_s2_q, clk_s3_q;
	reg din_s1_q, din_s2_q;
	reg [7:0] stat_sys_q, stat_osc_q, stat_cal_q;
	reg [7:0] regs_q [0:`SPR_NREG-1];
	reg [4:0] cnt_q;
	reg [14:0] hdr_q;
	reg [6:0] dat_q;
	reg [14:0] addr_q;
	reg read_q;
	reg [7:0] tx_q;
	reg sdo_q, oe_q;
	integer i;

	wire active = ~sel_s2_q;
	wire rise = clk_s2_q & ~clk_s3_q;
	wire fall = ~clk_s2_q & clk_s3_q;
	wire [14:0] hdr_addr = {hdr_q[13:0], din_s2_q};
	wire address_direction_up = regs_q[`SPR_I_CFG_A][`SPR_CFG_A_DIR_UP];
	wire hold = regs_q[`SPR_I_USR_CFG][`SPR_USR_ADDR_HOLD];
	wire [14:0] addr_next = hold ? addr_q :
		(address_direction_up ? addr_q + 15'h0001 : addr_q - 15'h0001);

	// map address to storage slot; bit 6 marks a listed address
	function [6:0] slot;
		input [14:0] a;
		begin
			if (a == `SPR_A_CFG_A) slot = {1'b1, 6'd0};
			else if (a == `SPR_A_DEV_CFG) slot = {1'b1, 6'd1};
			else if (a == `SPR_A_MAKER_LO) slot = {1'b1, 6'd2};
			else if (a == `SPR_A_MAKER_HI) slot = {1'b1, 6'd3};
			else if (a == `SPR_A_USR_CFG) slot = {1'b1, 6'd4};
			else if (a == `SPR_A_CLK0) slot = {1'b1, 6'd5};
			else if (a == `SPR_A_CLK1) slot = {1'b1, 6'd6};
			else if (a == `SPR_A_CLK2) slot = {1'b1, 6'd7};
			else if (a == `SPR_A_SYSREF) slot = {1'b1, 6'd8};
			else if (a == `SPR_A_FS_LO) slot = {1'b1, 6'd9};
			else if (a == `SPR_A_FS_HI) slot = {1'b1, 6'd10};
			else if (a == `SPR_A_LP1) slot = {1'b1, 6'd11};
			else if (a == `SPR_A_TMSTP) slot = {1'b1, 6'd12};
			else if (a == `SPR_A_REFO) slot = {1'b1, 6'd13};
			else if (a == `SPR_A_DIV_VP) slot = {1'b1, 6'd14};
			else if (a == `SPR_A_DIV_N) slot = {1'b1, 6'd15};
			else if (a == `SPR_A_OSC_CTL) slot = {1'b1, 6'd16};
			else if (a == `SPR_A_SER_EMPH) slot = {1'b1, 6'd17};
			else if (a == `SPR_A_TRIG) slot = {1'b1, 6'd18};
			else if (a == `SPR_A_PIN_OVR) slot = {1'b1, 6'd19};
			else if (a == `SPR_A_OSC_TRIM) slot = {1'b1, 6'd20};
			else if (a == `SPR_A_CAL_RST) slot = {1'b1, 6'd21};
			else if (a == `SPR_A_OSC_CAL) slot = {1'b1, 6'd22};
			else if (a == `SPR_A_OSC_STATE) slot = {1'b1, 6'd23};
			else if (a == `SPR_A_CAL_ON) slot = {1'b1, 6'd24};
			else if (a == `SPR_A_CAL_S0) slot = {1'b1, 6'd25};
			else if (a == `SPR_A_CAL_S1) slot = {1'b1, 6'd26};
			else if (a == `SPR_A_CAL_MEAN) slot = {1'b1, 6'd27};
			else if (a == `SPR_A_CAL_STATE) slot = {1'b1, 6'd28};
			else if (a == `SPR_A_CAL_PIN) slot = {1'b1, 6'd29};
			else if (a == `SPR_A_CAL_TRIG) slot = {1'b1, 6'd30};
			else if (a == `SPR_A_CAL_LOWP) slot = {1'b1, 6'd31};
			else if (a == `SPR_A_GAIN_DAC) slot = {1'b1, 6'd32};
			else if (a == `SPR_A_BANDGAP) slot = {1'b1, 6'd33};
			else if (a == `SPR_A_TERM_A) slot = {1'b1, 6'd34};
			else if (a == `SPR_A_TERM_B) slot = {1'b1, 6'd35};
			else if (a == `SPR_A_TERM_C) slot = {1'b1, 6'd36};
			else if (a == `SPR_A_TERM_D) slot = {1'b1, 6'd37};
			else if (a == `SPR_A_SRC_DLY) slot = {1'b1, 6'd38};
			else if (a == `SPR_A_SEL_DLY) slot = {1'b1, 6'd39};
			else if (a == `SPR_A_DITHER) slot = {1'b1, 6'd40};
			else if (a == `SPR_A_LSB_OUT) slot = {1'b1, 6'd41};
			else if (a == `SPR_A_SERDES_EN) slot = {1'b1, 6'd42};
			else if (a == `SPR_A_LINK_MODE) slot = {1'b1, 6'd43};
			else slot = 7'h00;
		end
	endfunction

	// reset value of each slot
	function [7:0] reset_of;
		input [5:0] s;
		begin
			case (s)
				6'd0: reset_of = `SPR_R_CFG_A;
				6'd5: reset_of = `SPR_R_CLK0;
				6'd7: reset_of = `SPR_R_CLK2;
				6'd10: reset_of = `SPR_R_FS_HI;
				6'd11: reset_of = `SPR_R_LP1;
				6'd13: reset_of = `SPR_R_ONE;
				6'd15: reset_of = `SPR_R_DIV_N;
				6'd16: reset_of = `SPR_R_OSC_CTL;
				6'd22: reset_of = `SPR_R_OSC_CAL;
				6'd24: reset_of = `SPR_R_ONE;
				6'd25: reset_of = `SPR_R_ONE;
				6'd26: reset_of = `SPR_R_ONE;
				6'd27: reset_of = `SPR_R_CAL_MEAN;
				6'd30: reset_of = `SPR_R_ONE;
				6'd31: reset_of = `SPR_R_CAL_LOWP;
				6'd42: reset_of = `SPR_R_ONE;
				default: reset_of = `SPR_R_ZERO;
			endcase
		end
	endfunction

	// read-only slots never take writes
	function is_ro;
		input [5:0] s;
		begin
			is_ro = (s == 6'd2) | (s == 6'd3) | (s == 6'd8) | (s == 6'd23) | (s == 6'd28);
		end
	endfunction

	// read value; unlisted addresses read zero
	function [7:0] read_of;
		input [14:0] a;
		reg [6:0] s;
		begin
			s = slot(a);
			if (!s[6]) read_of = 8'h00;
			else if (s[5:0] == 6'd2) read_of = MAKER_CODE[7:0];
			else if (s[5:0] == 6'd3) read_of = MAKER_CODE[15:8];
			else if (s[5:0] == 6'd8) read_of = stat_sys_q;
			else if (s[5:0] == 6'd23) read_of = stat_osc_q;
			else if (s[5:0] == 6'd28) read_of = stat_cal_q;
			else read_of = regs_q[s[5:0]];
		end
	endfunction

	wire [6:0] wr_slot = slot(addr_q);
	wire [7:0] rd_hdr = read_of(hdr_addr);
	wire [7:0] rd_next = read_of(addr_next);

	// pin synchronisers and status capture
	always @(posedge clock) begin
		if (!reset_n) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
			stat_sys_q <= 8'h00;
			stat_osc_q <= 8'h00;
			stat_cal_q <= 8'h00;
		end else begin
			sel_s1_q <= serial_select_n;
			sel_s2_q <= sel_s1_q;
			clk_s1_q <= serial_clock;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			din_s1_q <= serial_data_in;
			din_s2_q <= din_s1_q;
			stat_sys_q <= sysref_capture_window;
			stat_osc_q <= osc_cal_state;
			stat_cal_q <= calibration_state;
		end
	end

	// frame engine; no timeout, so a stopped clock simply holds state
	always @(posedge clock) begin
		if (!reset_n) begin
			cnt_q <= 5'd0;
			hdr_q <= 15'h0000;
			dat_q <= 7'h00;
			addr_q <= 15'h0000;
			read_q <= 1'b0;
			tx_q <= 8'h00;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			for (i = 0; i < `SPR_NREG; i = i + 1) begin
				regs_q[i] <= reset_of(i[5:0]);
			end
		end else if (!active) begin
			cnt_q <= 5'd0;
			oe_q <= 1'b0;
			read_q <= 1'b0;
		end else if (rise) begin
			if (cnt_q < `SPR_HDR_BITS) begin
				hdr_q <= {hdr_q[13:0], din_s2_q};
				cnt_q <= cnt_q + 5'd1;
				if (cnt_q == `SPR_HDR_BITS - 5'd1) begin
					addr_q <= hdr_addr;
					read_q <= hdr_q[14];
					if (hdr_q[14]) begin
						tx_q <= rd_hdr;
						sdo_q <= rd_hdr[7];
						oe_q <= 1'b1;
					end
				end
			end else begin
				dat_q <= {dat_q[5:0], din_s2_q};
				if (cnt_q == `SPR_FRAME_LAST) begin
					cnt_q <= `SPR_HDR_BITS;
					addr_q <= addr_next;
					if (!read_q && wr_slot[6] && !is_ro(wr_slot[5:0])) begin
						regs_q[wr_slot[5:0]] <= {dat_q, din_s2_q};
					end
					if (read_q) begin
						tx_q <= rd_next;
						sdo_q <= rd_next[7];
					end
				end else begin
					cnt_q <= cnt_q + 5'd1;
				end
			end
		end else if (fall && read_q && cnt_q > `SPR_HDR_BITS) begin
			tx_q <= {tx_q[6:0], 1'b0};
			sdo_q <= tx_q[6];
		end
	end

	// registered pin drive
	always @(posedge clock) begin
		if (!reset_n) begin
			serial_data_out <= 1'b0;
			serial_data_out_oe <= 1'b0;
		end else begin
			serial_data_out <= sdo_q;
			serial_data_out_oe <= oe_q & active;
		end
	end

endmodule
`default_nettype wire

// *** spr_port_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module spr_port_checker (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// serial pins
	input wire logic serial_select_n,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe
);
	logic sc_q;
	logic flag_q;
	logic [7:0] cnt_q;
	logic [3:0] fall_q;
	logic [3:0] rise_q;
	wire rise = serial_clock & ~sc_q;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// pin-level rise count and direction bit of the frame in progress
	always @(posedge clock) begin
		sc_q <= serial_clock;
		if (!reset_n || serial_select_n) begin
			cnt_q <= 8'h00;
			flag_q <= 1'b0;
		end else if (rise) begin
			cnt_q <= cnt_q + {7'h00, cnt_q != 8'hff};
			if (cnt_q == 8'h00)
				flag_q <= serial_data_in;
		end
		if (!reset_n)
			fall_q <= 4'hf;
		else if (sc_q && !serial_clock)
			fall_q <= 4'h0;
		else if (fall_q != 4'hf)
			fall_q <= fall_q + 4'h1;
		if (!reset_n)
			rise_q <= 4'hf;
		else if (rise)
			rise_q <= 4'h0;
		else if (rise_q != 4'hf)
			rise_q <= rise_q + 4'h1;
	end
	a_hdr_quiet: assert property (!serial_select_n && cnt_q < 8'd16 |-> !serial_data_out_oe)
		else $error("output driven during frame header");
	a_write_quiet: assert property (!serial_select_n && cnt_q != 8'h00 && !flag_q |-> !serial_data_out_oe)
		else $error("output driven during write frame");
	a_oe_on_read: assert property (rise && !serial_select_n && cnt_q == 8'd15 && flag_q |-> ##[2:6] serial_data_out_oe)
		else $error("read data not driven after address");
	a_oe_start: assert property ($rose(serial_data_out_oe) |-> cnt_q == 8'd16 && flag_q)
		else $error("output enabled at wrong bit");
	a_oe_hold: assert property (serial_data_out_oe && !serial_select_n |=> serial_data_out_oe)
		else $error("output released inside read");
	a_oe_drop: assert property ($rose(serial_select_n) |-> ##[1:6] !serial_data_out_oe)
		else $error("output still driven after deselect");
	a_sel_idle: assert property (serial_select_n [*8] |-> !serial_data_out_oe)
		else $error("output driven while deselected");
	a_shift_fall: assert property ($changed(serial_data_out) && serial_data_out_oe &&
		$past(serial_data_out_oe) |-> fall_q <= 4'd6 || rise_q <= 4'd6)
		else $error("read data changed without clock fall");
	cover property (rise && cnt_q == 8'd23 && !flag_q);
	cover property (cnt_q == 8'd40 && serial_data_out_oe);
	cover property ($rose(serial_select_n) && cnt_q == 8'd21);
endmodule
bind spr_port spr_port_checker u_chk (.*);
`default_nettype wire

// *** spr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module spr_host (
	// clock and read-back
	input wire logic clock,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	// serial pins
	output var logic serial_select_n,
	output var logic serial_clock,
	output var logic serial_data_in
);
	int half = 4;
	int stall = 0;
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	initial begin
		serial_select_n = 1'b1;
		serial_clock = 1'b0;
		serial_data_in = 1'b0;
	end
	// data set with clock low, sampled just before the rise
	task automatic bitx(input logic b, output logic s);
		serial_data_in = b;
		repeat (half + stall) @(posedge clock);
		#1 s = serial_data_out;
		serial_clock = 1'b1;
		repeat (half) @(posedge clock);
		#1 serial_clock = 1'b0;
	endtask
	task automatic xfer(input logic rd, input logic [14:0] a, input int nb, input int cut);
		logic [15:0] h;
		logic [7:0] v;
		logic [7:0] r;
		logic s;
		h = {rd, a};
		serial_select_n = 1'b0;
		for (int j = 0; j < 16 + 8 * nb - cut; j++) begin
			if (j >= 16 && j % 8 == 0)
				v = tx_q.pop_front();
			bitx(j < 16 ? h[15 - j] : v[7 - j % 8], s);
			r = {r[6:0], s};
			if (j >= 16 && j % 8 == 7)
				rx_q.push_back(r);
		end
		repeat (half) @(posedge clock);
		#1 serial_select_n = 1'b1;
		serial_data_in = ~serial_data_in;
		repeat (2 * half) @(posedge clock);
		#1;
	endtask
endmodule
`default_nettype wire

// *** serial_register_access_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_register_access_port_bench;
	logic clock, reset_n, serial_select_n, serial_clock, serial_data_in, serial_data_out, serial_data_out_oe;
	logic [7:0] sysref_capture_window, osc_cal_state, calibration_state;
	int n_mismatch = 0;
	int check_count = 0;
	int seed = 19163;
	int m[int] = '{9'h000: 8'h30, 9'h00c: 8'h21, 9'h00d: 8'h7e, 9'h010: 8'h00, 9'h029: 8'h80, 9'h02b: 8'h10,
		9'h031: 8'ha0, 9'h037: 8'h4b, 9'h03c: 8'h01, 9'h03e: 8'h20, 9'h03f: 8'h4f, 9'h05d: 8'h40, 9'h061: 8'h01,
		9'h062: 8'h01, 9'h065: 8'h01, 9'h068: 8'h61, 9'h06c: 8'h01, 9'h06e: 8'h88, 10'h200: 8'h01};
	// maker code value is arbitrary
	spr_port #(.MAKER_CODE(16'h7e21)) DUT (.*);
	spr_host host (.*);
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	function automatic int rv(int a);
		case (a)
			9'h02c: return sysref_capture_window;
			9'h05e: return osc_cal_state;
			9'h06a: return calibration_state;
			default: return m.exists(a) ? m[a] : 0;
		endcase
	endfunction
	function automatic void wr(int a, int d);
		if (!(a inside {9'h00c, 9'h00d, 9'h02c, 9'h05e, 9'h06a}))
			m[a] = d;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic rd, input int a, input int nb, input int cut = 0, input int d = -1);
		int e[$];
		int p;
		p = a;
		if (rd)
			{sysref_capture_window, osc_cal_state, calibration_state} = 24'($random(seed));
		for (int k = 0; k < nb; k++) begin
			host.tx_q.push_back(8'(d < 0 ? $random(seed) : d));
			if (rd)
				e.push_back(rv(p));
			else if (k < nb - (cut > 0))
				wr(p, host.tx_q[k]);
			p = m[9'h010][0] ? p : m[0][5] ? (p + 1) & 15'h7fff : (p - 1) & 15'h7fff;
		end
		host.rx_q.delete();
		host.xfer(rd, a[14:0], nb, cut);
		foreach (e[k])
			chk(host.rx_q.pop_front(), e[k][7:0]);
	endtask
	task report_and_stop;
		if (n_mismatch == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		{sysref_capture_window, osc_cal_state, calibration_state} = 24'($random(seed));
		repeat (10) @(posedge clock);
		#1 reset_n = 1'b1;
		repeat (5) @(posedge clock);
		#1;
		acc(1, 0, 130);
		acc(1, 10'h160, 1);
		acc(1, 10'h200, 2);
		acc(0, 9'h03d, 3);
		acc(0, 9'h02c, 1);
		acc(0, 9'h00c, 1);
		acc(1, 9'h03d, 3);
		acc(1, 9'h00c, 1);
		acc(1, 9'h02c, 1);
		acc(0, 9'h037, 1, 3);
		acc(1, 9'h037, 1);
		acc(0, 0, 1, 0, 8'h10);
		acc(1, 9'h03f, 3);
		acc(1, 0, 2);
		acc(0, 0, 1, 0, 8'h30);
		acc(0, 9'h010, 1, 0, 8'h01);
		acc(0, 9'h03b, 3);
		acc(1, 9'h03b, 2);
		acc(0, 9'h010, 1, 0, 8'h00);
		host.stall = 40;
		acc(1, 9'h061, 2);
		host.stall = 0;
		acc(1, 9'h062, 1);
		report_and_stop;
	end
	initial begin
		#1_000_000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
`default_nettype wire
